// *** design/ddr_read_params.svh ***
// timing, field and size constants for the read burst path
`ifndef DDR_READ_PARAMS_SVH
`define DDR_READ_PARAMS_SVH

`define DRB_SLOTS 80
`define DRB_SLOT_W 7
`define DRB_BL8_CYCLES 7'h04
`define DRB_BC4_CYCLES 7'h02
`define DRB_CCD_SHORT 8'h04
`define DRB_CCD_LONG 8'h06
`define DRB_BAD_2T_SPACING 8'h05
`define DRB_BURST_FIXED8 2'h0
`define DRB_BURST_OTF 2'h1
`define DRB_BURST_FIXED4 2'h2
`define DRB_AL_ZERO 2'h0
`define DRB_AL_CL_M1 2'h1
`define DRB_AL_CL_M2 2'h2
`define DRB_PIN_BITS 9
`define DRB_DQ_W 8
`define DRB_FIFO_DEPTH 16
`define DRB_BANKS 16

`endif

// *** design/ddr_read_pkg.sv ***
// types shared by the read burst path
package ddr_read_pkg;

    typedef enum logic [1:0] {
        SLOT_IDLE = 2'b00,
        SLOT_PRE  = 2'b01,
        SLOT_DATA = 2'b10
    } slot_kind_t;

endpackage

// *** design/read_fifo.sv ***
// parameterised valid/ready fifo holding read data beats
`timescale 1ns/1ps
`default_nettype none

module read_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready_out = (count_q != (AW+1)'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign out_data_out = mem_q[rd_ptr_q];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            case ({push, pop})
                2'b10: count_q <= count_q + 1'b1;
                2'b01: count_q <= count_q - 1'b1;
                default: count_q <= count_q;
            endcase
        end
    end

endmodule

`default_nettype wire

// *** design/ddr_read_burst_timing.sv ***
// read burst path of a ddr sdram: command capture, latency, strobe and data drive
//
// Function
// [R01] Bursts are fixed eight, fixed chop-four, or chosen per read by the burst-select bit (low four, high eight).
// [R02] A read with the auto-precharge bit low leaves its bank open after the burst.
// [R03] A read with the auto-precharge bit high precharges its bank once the burst finishes.
// [R04] Length eight applies for burst field 00, or for field 01 with the burst-select bit high.
// [R05] A length-eight burst releases strobe and data at the rising clock edge read latency plus four after the read.
// [R06] A chop-four burst releases strobe and data at the rising clock edge read latency plus two after the read.
// [R07] Read latency is additive latency plus CAS latency, additive being zero, CAS minus one or CAS minus two.
// [R08] The controller must not space reads five cycles apart when the two-clock preamble is selected.
// [R09] Length-eight reads four cycles apart to different bank groups come back as back-to-back bursts.
// [R10] With one-clock preamble, reads five cycles apart are taken and the second burst gets a fresh preamble.
// [R11] With two-clock preamble, reads six cycles apart are taken and each burst gets its own preamble.
// [R12] The strobe-to-data relation is only guaranteed while the delay-locked loop is enabled and locked.
// [R13] Data beats are launched on both strobe edges, edge aligned with the strobe.
// [R14] The postamble is half a clock whichever preamble length is selected.
// [R15] Column commands keep the short spacing across bank groups and the long spacing within one.
// [R16] A length-eight burst carries eight beats and a chop-four burst four, one per strobe edge.
// [R17] Before the first beat the strobe is driven low for one or two clocks as the preamble setting says.
`include "ddr_read_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ddr_read_burst_timing
    import ddr_read_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    // memory clock and command pins from the controller
    input wire logic ck_in,
    input wire logic cmd_read_in,
    input wire logic cmd_activate_in,
    input wire logic auto_precharge_addr_bit_in,
    input wire logic burst_select_addr_bit_in,
    input wire logic [1:0] bank_group_in,
    input wire logic [1:0] bank_addr_in,
    // mode settings
    input wire logic [1:0] burst_mode_in,
    input wire logic [5:0] cas_latency_in,
    input wire logic [1:0] additive_latency_in,
    input wire logic preamble_two_clk_in,
    input wire logic dll_locked_in,
    // read data supplied by the array side
    input wire logic rd_data_valid_in,
    output logic rd_data_ready_out,
    input wire logic [`DRB_DQ_W-1:0] rd_data_in,
    // data and strobe pins, enables active low
    output logic [`DRB_DQ_W-1:0] dq_out,
    output logic dq_oe_n_out,
    output logic dqs_t_out,
    output logic dqs_c_out,
    output logic dqs_oe_n_out,
    // bank and status
    output logic [`DRB_BANKS-1:0] bank_open_out,
    output logic precharge_pulse_out,
    output logic [3:0] precharge_bank_out,
    output logic ccd_violation_out,
    output logic preamble_spacing_err_out,
    output logic underrun_out
);

    function automatic logic is_burst_eight(input logic [1:0] mode, input logic sel);
        is_burst_eight = (mode == `DRB_BURST_FIXED8) || ((mode == `DRB_BURST_OTF) && sel);
    endfunction

    function automatic logic [6:0] burst_cycles(input logic eight);
        burst_cycles = eight ? `DRB_BL8_CYCLES : `DRB_BC4_CYCLES;
    endfunction

    // pin synchroniser: stage 1 feeds stage 2 only, a change counts once 2 and 3 agree
    logic [`DRB_PIN_BITS-1:0] pins;
    logic [`DRB_PIN_BITS-1:0] sync1_q;
    logic [`DRB_PIN_BITS-1:0] sync2_q;
    logic [`DRB_PIN_BITS-1:0] sync3_q;
    logic [`DRB_PIN_BITS-1:0] filt_q;
    logic ck_prev_q;

    assign pins = {ck_in, cmd_read_in, cmd_activate_in, auto_precharge_addr_bit_in,
                   burst_select_addr_bit_in, bank_group_in, bank_addr_in};

    genvar gi;
    generate
        for (gi = 0; gi < `DRB_PIN_BITS; gi++) begin : g_sync
            always_ff @(posedge mclk_in) begin
                if (!rstn_in) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                    filt_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pins[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        filt_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    logic ck_lvl;
    logic rd_lvl;
    logic act_lvl;
    logic ap_lvl;
    logic bs_lvl;
    logic [3:0] bank_lvl;
    logic ck_rise;
    logic ck_fall;

    assign ck_lvl = filt_q[8];
    assign rd_lvl = filt_q[7];
    assign act_lvl = filt_q[6];
    assign ap_lvl = filt_q[5];
    assign bs_lvl = filt_q[4];
    assign bank_lvl = filt_q[3:0];
    assign ck_rise = ck_lvl & ~ck_prev_q;
    assign ck_fall = ~ck_lvl & ck_prev_q;

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            ck_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_lvl;
        end
    end

    // latency and burst shape of the read taken on this edge
    logic [6:0] cl_ext;
    logic [6:0] al_val;
    logic [6:0] rl_val;
    logic [6:0] pre_len;
    logic [6:0] burst_len;
    logic rd_take;

    assign cl_ext = {1'b0, cas_latency_in};
    always_comb begin
        unique case (additive_latency_in)
            `DRB_AL_CL_M1: al_val = cl_ext - 7'h01;
            `DRB_AL_CL_M2: al_val = cl_ext - 7'h02;
            default: al_val = 7'h00;
        endcase
    end
    assign rl_val = al_val + cl_ext; // R07
    assign pre_len = preamble_two_clk_in ? 7'h02 : 7'h01; // R17
    assign burst_len = burst_cycles(is_burst_eight(burst_mode_in, bs_lvl)); // R01 R04 R16
    assign rd_take = ck_rise & rd_lvl;

    // schedule: one entry per future clock cycle, entry 0 is the cycle under way
    slot_kind_t slot_q [`DRB_SLOTS];
    slot_kind_t slot_d [`DRB_SLOTS];
    logic slot_ap_q [`DRB_SLOTS];
    logic slot_ap_d [`DRB_SLOTS];
    logic [3:0] slot_bank_q [`DRB_SLOTS];
    logic [3:0] slot_bank_d [`DRB_SLOTS];

    always_comb begin
        logic [6:0] idx;
        idx = '0;
        for (int j = 0; j < `DRB_SLOTS; j++) begin
            slot_d[j] = slot_q[j];
            slot_ap_d[j] = slot_ap_q[j];
            slot_bank_d[j] = slot_bank_q[j];
        end
        if (ck_rise) begin
            for (int j = 0; j < `DRB_SLOTS - 1; j++) begin
                slot_d[j] = slot_q[j+1];
                slot_ap_d[j] = slot_ap_q[j+1];
                slot_bank_d[j] = slot_bank_q[j+1];
            end
            slot_d[`DRB_SLOTS-1] = SLOT_IDLE;
            slot_ap_d[`DRB_SLOTS-1] = 1'b0;
            slot_bank_d[`DRB_SLOTS-1] = 4'h0;
            if (rd_take) begin
                for (int j = 0; j < `DRB_SLOTS; j++) begin
                    idx = 7'(j);
                    // a preamble never overwrites a burst already queued: back to back
                    if ((idx >= rl_val - pre_len) && (idx < rl_val) && (slot_d[j] == SLOT_IDLE)) begin
                        slot_d[j] = SLOT_PRE; // R10 R11 R17
                    end
                    if ((idx >= rl_val) && (idx < rl_val + burst_len)) begin
                        slot_d[j] = SLOT_DATA; // R09 R16
                        slot_ap_d[j] = (idx == rl_val + burst_len - 7'h01) && ap_lvl; // R02 R03
                        slot_bank_d[j] = bank_lvl;
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            for (int j = 0; j < `DRB_SLOTS; j++) begin
                slot_q[j] <= SLOT_IDLE;
                slot_ap_q[j] <= 1'b0;
                slot_bank_q[j] <= 4'h0;
            end
        end else begin
            for (int j = 0; j < `DRB_SLOTS; j++) begin
                slot_q[j] <= slot_d[j];
                slot_ap_q[j] <= slot_ap_d[j];
                slot_bank_q[j] <= slot_bank_d[j];
            end
        end
    end

    // beat source; beats are only pulled when due so the fifo fills and stalls the feeder
    logic fifo_valid;
    logic [`DRB_DQ_W-1:0] fifo_data;
    logic beat_tick;

    assign beat_tick = (ck_rise && (slot_d[0] == SLOT_DATA)) || (ck_fall && (slot_q[0] == SLOT_DATA)); // R13 R16

    read_fifo #(
        .WIDTH(`DRB_DQ_W),
        .DEPTH(`DRB_FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .in_valid_in(rd_data_valid_in),
        .in_ready_out(rd_data_ready_out),
        .in_data_in(rd_data_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(beat_tick),
        .out_data_out(fifo_data)
    );

    // pin drive, updated on each half clock
    logic [`DRB_DQ_W-1:0] dq_q;
    logic dq_oe_n_q;
    logic dqs_t_q;
    logic dqs_oe_n_q;
    logic underrun_q;

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            dq_q <= 8'h00;
            dq_oe_n_q <= 1'b1;
            dqs_t_q <= 1'b0;
            dqs_oe_n_q <= 1'b1;
            underrun_q <= 1'b0;
        end else begin
            underrun_q <= beat_tick & ~fifo_valid;
            if (beat_tick) begin
                // an empty fifo still yields a beat so the burst keeps its length
                dq_q <= fifo_valid ? fifo_data : 8'h00; // R13
            end
            if (ck_rise) begin
                unique case (slot_d[0])
                    SLOT_DATA: begin
                        dqs_t_q <= 1'b1; // R13
                        dqs_oe_n_q <= ~dll_locked_in; // R12
                        dq_oe_n_q <= ~dll_locked_in; // R12
                    end
                    SLOT_PRE: begin
                        dqs_t_q <= 1'b0; // R17
                        dqs_oe_n_q <= ~dll_locked_in; // R12
                        dq_oe_n_q <= 1'b1;
                    end
                    default: begin
                        // release at read latency plus burst cycles
                        dqs_t_q <= 1'b0;
                        dqs_oe_n_q <= 1'b1; // R05 R06
                        dq_oe_n_q <= 1'b1; // R05 R06
                    end
                endcase
            end else if (ck_fall && (slot_q[0] == SLOT_DATA)) begin
                // the low half after the last beat is the half-clock postamble
                dqs_t_q <= 1'b0; // R13 R14
            end
        end
    end

    assign dq_out = dq_q;
    assign dq_oe_n_out = dq_oe_n_q;
    assign dqs_t_out = dqs_t_q;
    assign dqs_c_out = ~dqs_t_q;
    assign dqs_oe_n_out = dqs_oe_n_q;
    assign underrun_out = underrun_q;

    // bank state: activate opens, auto-precharge closes at the end of the burst
    logic [`DRB_BANKS-1:0] bank_open_q;
    logic pchg_q;
    logic [3:0] pchg_bank_q;
    logic burst_done_ap;

    assign burst_done_ap = ck_rise && (slot_q[0] == SLOT_DATA) && slot_ap_q[0];

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            bank_open_q <= '0;
            pchg_q <= 1'b0;
            pchg_bank_q <= 4'h0;
        end else begin
            pchg_q <= burst_done_ap; // R03
            if (burst_done_ap) begin
                pchg_bank_q <= slot_bank_q[0];
                bank_open_q[slot_bank_q[0]] <= 1'b0; // R03
            end
            // an activate on the same edge wins over the precharge
            if (ck_rise && act_lvl) begin
                bank_open_q[bank_lvl] <= 1'b1; // R02
            end
        end
    end

    assign bank_open_out = bank_open_q;
    assign precharge_pulse_out = pchg_q;
    assign precharge_bank_out = pchg_bank_q;

    // read spacing checks, counted in memory clocks
    logic [7:0] since_rd_q;
    logic [1:0] last_bg_q;
    logic seen_rd_q;
    logic ccd_err_q;
    logic sp_err_q;
    logic [7:0] need_gap;

    assign need_gap = (bank_lvl[3:2] == last_bg_q) ? `DRB_CCD_LONG : `DRB_CCD_SHORT;

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            since_rd_q <= 8'hFF;
            last_bg_q <= 2'h0;
            seen_rd_q <= 1'b0;
            ccd_err_q <= 1'b0;
            sp_err_q <= 1'b0;
        end else begin
            ccd_err_q <= 1'b0;
            sp_err_q <= 1'b0;
            if (rd_take) begin
                ccd_err_q <= seen_rd_q && (since_rd_q + 8'h01 < need_gap); // R15
                sp_err_q <= seen_rd_q && preamble_two_clk_in &&
                            (since_rd_q + 8'h01 == `DRB_BAD_2T_SPACING); // R08
                since_rd_q <= 8'h00;
                last_bg_q <= bank_lvl[3:2];
                seen_rd_q <= 1'b1;
            end else if (ck_rise && (since_rd_q != 8'hFE)) begin
                since_rd_q <= since_rd_q + 8'h01;
            end
        end
    end

    assign ccd_violation_out = ccd_err_q;
    assign preamble_spacing_err_out = sp_err_q;

endmodule

`default_nettype wire

// *** bench/ddr_read_burst_chk.sv ***
// port assertions for the read burst path
`include "ddr_read_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ddr_read_burst_chk (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic dll_locked_in,
    input wire logic [`DRB_DQ_W-1:0] dq_out,
    input wire logic dq_oe_n_out,
    input wire logic dqs_t_out,
    input wire logic dqs_c_out,
    input wire logic dqs_oe_n_out,
    input wire logic [`DRB_BANKS-1:0] bank_open_out,
    input wire logic precharge_pulse_out,
    input wire logic [3:0] precharge_bank_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    logic [4:0] edges_q;
    // strobe edges per driven stretch; whole bursts come in fours
    always_ff @(posedge mclk_in) begin
        if (!rstn_in || dqs_oe_n_out) begin
            edges_q <= 5'h00;
        end else if ($changed(dqs_t_out)) begin
            edges_q <= edges_q + 5'h01;
        end
    end
    sequence pre_start;
        $fell(dqs_oe_n_out);
    endsequence
    sequence post_end;
        $rose(dqs_oe_n_out);
    endsequence
    a_strobe_pair:
        assert property (dqs_c_out == ~dqs_t_out) else $error("strobe halves not complementary");
    a_dll_quiet:
        assert property (!dll_locked_in && !$past(dll_locked_in) && !$past(dll_locked_in, 2)
            |-> dqs_oe_n_out && dq_oe_n_out) else $error("pins driven while loop unlocked");
    a_strobe_under:
        assert property (!dq_oe_n_out |-> !dqs_oe_n_out) else $error("data driven without strobe");
    a_preamble_low:
        assert property (pre_start |-> (!dqs_t_out && dq_oe_n_out) [*8]) else $error("preamble not low");
    a_postamble_half:
        assert property (post_end |-> !$past(dqs_t_out) && !$past(dqs_t_out, 3)) else $error("bad postamble");
    a_beat_hold:
        assert property ($changed(dqs_t_out) && !dqs_oe_n_out |=> $stable(dqs_t_out) [*3])
            else $error("strobe half cycle too short");
    a_data_aligned:
        assert property ($changed(dq_out) && !dq_oe_n_out && $past(!dq_oe_n_out) |-> $changed(dqs_t_out))
            else $error("data moved off a strobe edge");
    a_burst_edges:
        assert property (post_end |-> edges_q[1:0] == 2'h0 && edges_q != 5'h00) else $error("partial burst");
    a_precharge_close:
        assert property (precharge_pulse_out |-> ##[0:1] !bank_open_out[precharge_bank_out])
            else $error("bank left open after auto precharge");
endmodule

bind ddr_read_burst_timing ddr_read_burst_chk u_chk (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .dll_locked_in(dll_locked_in), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out), .dqs_t_out(dqs_t_out),
    .dqs_c_out(dqs_c_out), .dqs_oe_n_out(dqs_oe_n_out), .bank_open_out(bank_open_out),
    .precharge_pulse_out(precharge_pulse_out), .precharge_bank_out(precharge_bank_out));
`default_nettype wire

// *** bench/ddr_ctrl_model.sv ***
// controller side model: memory clock, commands and beat capture
`timescale 1ns/1ps
`default_nettype none

module ddr_ctrl_model (
    output logic ck_out,
    output logic cmd_read_out,
    output logic cmd_activate_out,
    output logic ap_out,
    output logic bs_out,
    output logic [1:0] bg_out,
    output logic [1:0] ba_out,
    input wire logic [7:0] dq_in,
    input wire logic dq_oe_n_in,
    input wire logic dqs_t_in,
    input wire logic dqs_oe_n_in
);
    int ck_cnt = 0;
    int cmd_at = 0;
    int pre_at = 0;
    int rel_at = 0;
    int n_rel = 0;
    logic [7:0] got_q[$];
    initial begin
        cmd_read_out = 1'b0;
        cmd_activate_out = 1'b0;
        ap_out = 1'b0;
        bs_out = 1'b0;
        bg_out = 2'h0;
        ba_out = 2'h0;
        ck_out = 1'b0;
        forever #40 ck_out = ~ck_out;
    end
    always @(posedge ck_out) ck_cnt++;
    // pins change at ck fall so they are steady around the sampling rise
    task automatic issue(input logic rd, input logic [1:0] bg, input logic [1:0] ba,
                         input logic ap, input logic bs, input int gap);
        @(negedge ck_out);
        cmd_read_out = rd;
        cmd_activate_out = ~rd;
        bg_out = bg;
        ba_out = ba;
        ap_out = ap;
        bs_out = bs;
        cmd_at = ck_cnt + 1;
        @(negedge ck_out);
        cmd_read_out = 1'b0;
        cmd_activate_out = 1'b0;
        // released lines show the inverse, never the stale value
        bg_out = ~bg;
        ba_out = ~ba;
        ap_out = ~ap;
        bs_out = ~bs;
        repeat (gap - 2) @(negedge ck_out);
    endtask
    always @(dqs_t_in) begin
        #1;
        if (dqs_oe_n_in === 1'b0 && dq_oe_n_in === 1'b0) got_q.push_back(dq_in);
    end
    always @(negedge dqs_oe_n_in) pre_at = ck_cnt - cmd_at;
    always @(posedge dqs_oe_n_in) begin
        rel_at = ck_cnt - cmd_at;
        n_rel++;
    end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the read burst path
`include "ddr_read_params.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic mclk_in, rstn_in, ck, cmd_rd, cmd_act, ap, bs, pre2, dll, vld, rdy, dq_oe_n, dqs_t, dqs_c, dqs_oe_n;
    logic pc_pulse, ccd_err, spc_err, und;
    logic [1:0] bg, ba, mode, al;
    logic [5:0] cas;
    logic [7:0] din, dq;
    logic [15:0] bank_open;
    logic [3:0] pc_bank;
    int n_fail = 0;
    int tests_run = 0;
    int seed = 62;
    int n_ccd = 0;
    int n_spc = 0;
    int n_pc = 0;
    int n_und = 0;
    int c0, s0, r0;
    logic [7:0] exp_q[$];
    logic [1:0] modes[5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic sel[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    int lens[5] = '{8, 4, 8, 4, 4};
    // rows: two-clock preamble, gap, same group, mode, beats, spacing faults, preamble faults
    int gaps[5][7] = '{'{0, 5, 0, 0, 16, 0, 0}, '{1, 6, 1, 0, 16, 0, 0}, '{1, 5, 0, 0, 16, 0, 1},
                       '{0, 3, 0, 2, 8, 1, 0}, '{0, 4, 1, 2, 8, 1, 0}};

    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    ddr_read_burst_timing dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .ck_in(ck), .cmd_read_in(cmd_rd),
        .cmd_activate_in(cmd_act), .auto_precharge_addr_bit_in(ap), .burst_select_addr_bit_in(bs),
        .bank_group_in(bg), .bank_addr_in(ba), .burst_mode_in(mode), .cas_latency_in(cas),
        .additive_latency_in(al), .preamble_two_clk_in(pre2), .dll_locked_in(dll), .rd_data_valid_in(vld),
        .rd_data_ready_out(rdy), .rd_data_in(din), .dq_out(dq), .dq_oe_n_out(dq_oe_n), .dqs_t_out(dqs_t),
        .dqs_c_out(dqs_c), .dqs_oe_n_out(dqs_oe_n), .bank_open_out(bank_open), .precharge_pulse_out(pc_pulse),
        .precharge_bank_out(pc_bank), .ccd_violation_out(ccd_err), .preamble_spacing_err_out(spc_err),
        .underrun_out(und));

    ddr_ctrl_model mc (.ck_out(ck), .cmd_read_out(cmd_rd), .cmd_activate_out(cmd_act), .ap_out(ap),
        .bs_out(bs), .bg_out(bg), .ba_out(ba), .dq_in(dq), .dq_oe_n_in(dq_oe_n), .dqs_t_in(dqs_t),
        .dqs_oe_n_in(dqs_oe_n));

    always @(posedge mclk_in) begin
        if (ccd_err === 1'b1) n_ccd++;
        if (spc_err === 1'b1) n_spc++;
        if (pc_pulse === 1'b1) n_pc++;
        if (und === 1'b1) n_und++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk_in);
            vld = 1'b1;
            din = 8'($random(seed));
            @(posedge mclk_in);
            while (rdy !== 1'b1) @(posedge mclk_in);
            exp_q.push_back(din);
        end
        @(negedge mclk_in);
        vld = 1'b0;
    endtask

    // waits for release, then compares every beat with the queued bytes
    task automatic finish_burst(input int beats, input int rl, input int tail, input int pre);
        for (int i = 0; i < 4000 && !(mc.got_q.size() >= beats && dqs_oe_n === 1'b1); i++) @(posedge mclk_in);
        check(mc.got_q.size(), beats);
        while (mc.got_q.size() > 0) check(mc.got_q.pop_front(), exp_q.size() > 0 ? exp_q.pop_front() : 8'h00);
        if (tail > 0) check(mc.rel_at, rl + tail);
        if (pre > 0) check(mc.pre_at, rl - pre);
    endtask

    initial begin
        rstn_in = 1'b0;
        mode = 2'h0;
        cas = 6'h06;
        al = 2'h0;
        pre2 = 1'b0;
        dll = 1'b1;
        vld = 1'b0;
        din = 8'h00;
        repeat (12) @(posedge mclk_in);
        @(negedge mclk_in);
        rstn_in = 1'b1;
        check({dqs_oe_n, dq_oe_n, rdy, bank_open}, {3'h7, 16'h0000});
        repeat (8) @(posedge mclk_in);
        for (int m = 0; m < 5; m++) begin
            @(negedge mclk_in);
            mode = modes[m];
            push(lens[m]);
            mc.issue(1'b1, 2'($random(seed)), 2'($random(seed)), 1'b0, sel[m], 2);
            finish_burst(lens[m], 6, lens[m] / 2, 1);
        end
        // additive code 3 falls back to zero, so read latency is the cas latency alone
        for (int a = 1; a < 4; a++) begin
            @(negedge mclk_in);
            al = 2'(a);
            pre2 = (a == 2);
            mode = 2'h0;
            push(8);
            mc.issue(1'b1, 2'h1, 2'h1, 1'b0, 1'b1, 2);
            finish_burst(8, a == 3 ? 6 : 12 - a, 4, a == 2 ? 2 : 1);
        end
        @(negedge mclk_in);
        al = 2'h0;
        pre2 = 1'b0;
        push(16);
        @(negedge mclk_in);
        check(rdy, 1'b0);
        r0 = mc.n_rel;
        mc.issue(1'b1, 2'h0, 2'h0, 1'b0, 1'b1, 4);
        mc.issue(1'b1, 2'h1, 2'h0, 1'b0, 1'b1, 2);
        finish_burst(16, 6, 4, 0);
        check(mc.n_rel - r0, 1);
        for (int g = 0; g < 5; g++) begin
            @(negedge mclk_in);
            pre2 = gaps[g][0][0];
            mode = 2'(gaps[g][3]);
            push(gaps[g][4]);
            c0 = n_ccd;
            s0 = n_spc;
            mc.issue(1'b1, 2'h1, 2'h0, 1'b0, 1'b1, gaps[g][1]);
            mc.issue(1'b1, gaps[g][2] ? 2'h1 : 2'h2, 2'h2, 1'b0, 1'b1, 2);
            finish_burst(gaps[g][4], 6, 0, 0);
            check(n_ccd - c0, gaps[g][5]);
            check(n_spc - s0, gaps[g][6]);
        end
        @(negedge mclk_in);
        pre2 = 1'b0;
        mode = 2'h0;
        mc.issue(1'b0, 2'h1, 2'h2, 1'b0, 1'b0, 2);
        mc.issue(1'b0, 2'h2, 2'h1, 1'b0, 1'b0, 2);
        push(16);
        mc.issue(1'b1, 2'h2, 2'h1, 1'b0, 1'b1, 2);
        finish_burst(8, 6, 4, 1);
        check(bank_open[9], 1'b1);
        c0 = n_pc;
        mc.issue(1'b1, 2'h1, 2'h2, 1'b1, 1'b1, 2);
        finish_burst(8, 6, 4, 1);
        repeat (4) @(posedge mclk_in);
        check({28'(n_pc - c0), pc_bank}, {28'h1, 4'h6});
        check({bank_open[6], bank_open[9]}, 2'b01);
        @(negedge mclk_in);
        dll = 1'b0;
        mode = 2'h2;
        push(4);
        mc.issue(1'b1, 2'h0, 2'h3, 1'b0, 1'b0, 2);
        repeat (120) @(posedge mclk_in);
        check(mc.got_q.size(), 0);
        repeat (4) void'(exp_q.pop_front());
        @(negedge mclk_in);
        dll = 1'b1;
        c0 = n_und;
        mc.issue(1'b1, 2'h3, 2'h0, 1'b0, 1'b0, 2);
        finish_burst(4, 6, 2, 1);
        check(n_und - c0 > 0, 1'b1);
        close_out;
    end

    initial begin
        #300000;
        n_fail++;
        close_out;
    end
endmodule
`default_nettype wire
